// >>> scxo_ctrl.sv
// Slow crystal oscillator control: registers, warm-up sequencing, pads
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Lock bit 12 set makes all later CTRL register writes ignored; mask and standby writes still apply.
// - Warm-up field bits 10:8 sets counter length in low-power osc ticks.
// - Codes 0..7 give 1,32,2048,4096,16384,32768,65536,131072 ticks.
// - After warm-up, wait three crystal cycles then set ready.
// - Request-driven mode runs oscillator only while a peripheral requests.
// - Without request-driven mode, oscillator runs whenever enabled.
// - In standby, keep-in-standby clear disables the oscillator.
// - In standby with keep set, normal request or continuous run stays.
// - Bit 5 enables automatic amplitude control.
// - Bit 3 gates the 32 kHz clock output.
// - Bit 2 selects crystal across pads or external clock on input pad.
// - Enable bit 1 turns oscillator on or off.
module scxo_ctrl #(
	parameter int ULP_DIV = scxo_pkg::ULP_DIV
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic CLK_REQUEST,
	input wire logic XOSC_CLK_TICK,
	output logic OSC_RUN,
	output logic OSC_READY,
	output logic AUTO_AMP_EN,
	output logic CLK32_OUT_EN,
	output logic XTAL_OUT_PAD_EN,
	output logic XTAL_IN_PAD_EN,
	output logic IRQ
);
	logic [15:0] ctrl_ff;
	logic standby_ff;
	logic [scxo_pkg::IRQ_W-1:0] status_ff;
	logic [scxo_pkg::IRQ_W-1:0] mask_ff;
	logic [scxo_pkg::ULP_CNT_W-1:0] warm_ff;
	logic [1:0] sync_ff;
	scxo_pkg::scxo_state_e state_ff;
	scxo_pkg::scxo_state_e nxt_state;
	logic ulp_tick;
	logic want_run;
	logic bus_req;
	logic wr_go;
	logic rd_go;
	logic ready_evt;
	logic lost_evt;
	logic [31:0] nxt_rdata;

	scxo_tick #(.DIV(ULP_DIV)) i_scxo_tick (
		.clk(REF_CLK),
		.rst(RST),
		.tick(ulp_tick)
	);

	// ************************************************
	// Bus slave
	// ************************************************
	// Single-cycle answer; ack drops for one cycle between requests
	assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr_go = bus_req && WB_WE_I;
	assign rd_go = bus_req && !WB_WE_I;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req;
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (WB_ADR_I)
			scxo_pkg::CTRL_OFFSET: begin
				nxt_rdata = {16'h0000, ctrl_ff};
			end
			scxo_pkg::STATUS_OFFSET: begin
				nxt_rdata = {30'h0, status_ff};
			end
			scxo_pkg::MASK_OFFSET: begin
				nxt_rdata = {30'h0, mask_ff};
			end
			scxo_pkg::CONTROL_OFFSET: begin
				nxt_rdata = {27'h0, state_ff == scxo_pkg::SCXO_READY,
					OSC_RUN, 2'h0, standby_ff};
			end
			default: begin
				nxt_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (rd_go) begin
			WB_DAT_O <= nxt_rdata;
		end
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= scxo_pkg::CTRL_RESET;
		end else if (wr_go && WB_ADR_I == scxo_pkg::CTRL_OFFSET &&
				!ctrl_ff[scxo_pkg::LOCK_BIT]) begin
			if (WB_SEL_I[0]) begin
				ctrl_ff[7:0] <= WB_DAT_I[7:0] & scxo_pkg::CTRL_WMASK[7:0];
			end
			if (WB_SEL_I[1]) begin
				ctrl_ff[15:8] <= WB_DAT_I[15:8] & scxo_pkg::CTRL_WMASK[15:8];
			end
		end
	end

	// Standby entry is software-driven here, since no sleep controller exists
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			standby_ff <= 1'b0;
		end else if (wr_go && WB_ADR_I == scxo_pkg::CONTROL_OFFSET &&
				WB_SEL_I[0]) begin
			standby_ff <= WB_DAT_I[scxo_pkg::STANDBY_CTL_BIT];
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mask_ff <= '0;
		end else if (wr_go && WB_ADR_I == scxo_pkg::MASK_OFFSET &&
				WB_SEL_I[0]) begin
			mask_ff <= WB_DAT_I[scxo_pkg::IRQ_W-1:0];
		end
	end

	// Set wins over the clear-on-read
	assign ready_evt = state_ff == scxo_pkg::SCXO_SYNC &&
		nxt_state == scxo_pkg::SCXO_READY;
	assign lost_evt = state_ff == scxo_pkg::SCXO_READY &&
		nxt_state == scxo_pkg::SCXO_OFF;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			status_ff <= '0;
		end else begin
			if (rd_go && WB_ADR_I == scxo_pkg::STATUS_OFFSET) begin
				status_ff <= {lost_evt, ready_evt};
			end else begin
				status_ff <= status_ff | {lost_evt, ready_evt};
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status_ff & mask_ff);
		end
	end

	// ************************************************
	// Run decision
	// ************************************************
	always_comb begin
		want_run = 1'b0;
		if (ctrl_ff[scxo_pkg::ENABLE_BIT]) begin
			if (standby_ff && !ctrl_ff[scxo_pkg::STDBY_BIT]) begin
				want_run = 1'b0;
			end else if (ctrl_ff[scxo_pkg::REQUEST_DRIVEN_RUN_BIT]) begin
				want_run = CLK_REQUEST;
			end else begin
				want_run = 1'b1;
			end
		end
	end

	// ************************************************
	// Warm-up sequencer
	// ************************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			scxo_pkg::SCXO_OFF: begin
				if (want_run) begin
					nxt_state = scxo_pkg::SCXO_WARM;
				end
			end
			scxo_pkg::SCXO_WARM: begin
				if (!want_run) begin
					nxt_state = scxo_pkg::SCXO_OFF;
				end else if (ulp_tick && warm_ff == 18'h00001) begin
					nxt_state = scxo_pkg::SCXO_SYNC;
				end
			end
			scxo_pkg::SCXO_SYNC: begin
				if (!want_run) begin
					nxt_state = scxo_pkg::SCXO_OFF;
				end else if (XOSC_CLK_TICK &&
						sync_ff == 2'(scxo_pkg::SYNC_CYCLES - 1)) begin
					nxt_state = scxo_pkg::SCXO_READY;
				end
			end
			scxo_pkg::SCXO_READY: begin
				if (!want_run) begin
					nxt_state = scxo_pkg::SCXO_OFF;
				end
			end
			default: begin
				nxt_state = scxo_pkg::SCXO_OFF;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_ff <= scxo_pkg::SCXO_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Load on entry so a new run always starts the full count
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			warm_ff <= '0;
		end else if (state_ff != scxo_pkg::SCXO_WARM) begin
			warm_ff <= scxo_pkg::warm_count(
				ctrl_ff[scxo_pkg::WARM_HI:scxo_pkg::WARM_LO]);
		end else if (ulp_tick) begin
			warm_ff <= warm_ff - 18'h00001;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sync_ff <= 2'h0;
		end else if (state_ff != scxo_pkg::SCXO_SYNC) begin
			sync_ff <= 2'h0;
		end else if (XOSC_CLK_TICK) begin
			sync_ff <= sync_ff + 2'h1;
		end
	end

	// ************************************************
	// Outputs and pads
	// ************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			OSC_RUN <= 1'b0;
			OSC_READY <= 1'b0;
			AUTO_AMP_EN <= 1'b0;
			CLK32_OUT_EN <= 1'b0;
			XTAL_OUT_PAD_EN <= 1'b0;
			XTAL_IN_PAD_EN <= 1'b0;
		end else begin
			OSC_RUN <= nxt_state != scxo_pkg::SCXO_OFF;
			OSC_READY <= nxt_state == scxo_pkg::SCXO_READY;
			AUTO_AMP_EN <= ctrl_ff[scxo_pkg::AAMP_BIT];
			// Output only once the clock is stable, to avoid runt pulses
			CLK32_OUT_EN <= ctrl_ff[scxo_pkg::OUT32_BIT] &&
				nxt_state == scxo_pkg::SCXO_READY;
			XTAL_IN_PAD_EN <= ctrl_ff[scxo_pkg::ENABLE_BIT];
			XTAL_OUT_PAD_EN <= ctrl_ff[scxo_pkg::ENABLE_BIT] &&
				ctrl_ff[scxo_pkg::XTAL_BIT];
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	// Independent tick count, so the table check does not lean on warm_ff
	logic [scxo_pkg::ULP_CNT_W-1:0] warm_seen_ff;
	logic [2:0] warm_sel_ff;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			warm_seen_ff <= '0;
			warm_sel_ff <= 3'h0;
		end else if (state_ff != scxo_pkg::SCXO_WARM) begin
			warm_seen_ff <= '0;
			warm_sel_ff <= ctrl_ff[scxo_pkg::WARM_HI:scxo_pkg::WARM_LO];
		end else if (ulp_tick) begin
			warm_seen_ff <= warm_seen_ff + 18'h00001;
		end
	end

	sequence warm_last_s;
		state_ff == scxo_pkg::SCXO_WARM && want_run && ulp_tick &&
			warm_ff == 18'h00001;
	endsequence

	lock_holds_a: assert property (@(posedge REF_CLK) disable iff (RST)
		ctrl_ff[scxo_pkg::LOCK_BIT] |=> $stable(ctrl_ff))
		else $error("locked config changed");
	ready_only_run_a: assert property (@(posedge REF_CLK) disable iff (RST)
		OSC_READY |-> OSC_RUN)
		else $error("ready without run");
	ready_via_sync_a: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(OSC_READY) |-> $past(state_ff) == scxo_pkg::SCXO_SYNC)
		else $error("ready skipped sync");
	sync_three_a: assert property (@(posedge REF_CLK) disable iff (RST)
		ready_evt |-> XOSC_CLK_TICK && sync_ff == 2'h2)
		else $error("sync count wrong");
	stdby_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
		standby_ff && !ctrl_ff[scxo_pkg::STDBY_BIT] |-> ##1 !OSC_RUN)
		else $error("run in standby");
	demand_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
		ctrl_ff[scxo_pkg::REQUEST_DRIVEN_RUN_BIT] && !CLK_REQUEST |=> !OSC_RUN)
		else $error("run without request");
	always_on_a: assert property (@(posedge REF_CLK) disable iff (RST)
		ctrl_ff[scxo_pkg::ENABLE_BIT] && !ctrl_ff[scxo_pkg::REQUEST_DRIVEN_RUN_BIT] &&
		!standby_ff |=> OSC_RUN)
		else $error("enabled osc not running");
	disable_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
		!ctrl_ff[scxo_pkg::ENABLE_BIT] |=> !OSC_RUN && !OSC_READY)
		else $error("disabled osc running");
	amp_follow_a: assert property (@(posedge REF_CLK) disable iff (RST)
		##1 AUTO_AMP_EN == $past(ctrl_ff[scxo_pkg::AAMP_BIT]))
		else $error("amplitude control mismatch");
	out_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
		CLK32_OUT_EN |-> OSC_READY)
		else $error("clock out while not ready");
	xtal_pad_a: assert property (@(posedge REF_CLK) disable iff (RST)
		XTAL_OUT_PAD_EN |-> XTAL_IN_PAD_EN)
		else $error("out pad without in pad");
	warm_len_a: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(state_ff == scxo_pkg::SCXO_WARM) |-> warm_ff ==
		scxo_pkg::warm_count($past(ctrl_ff[scxo_pkg::WARM_HI:scxo_pkg::WARM_LO])))
		else $error("warm count wrong");
	sync_entry_a: assert property (@(posedge REF_CLK) disable iff (RST)
		warm_last_s |=> state_ff == scxo_pkg::SCXO_SYNC)
		else $error("warm-up did not end");
	warm_ticks_a: assert property (@(posedge REF_CLK) disable iff (RST)
		warm_last_s |-> warm_seen_ff ==
		scxo_pkg::warm_count(warm_sel_ff) - 18'h00001)
		else $error("warm tick count wrong");
endmodule
`default_nettype wire

// >>> scxo_pkg.sv
// Package: register map, fields and timing constants of the slow crystal oscillator control
`default_nettype none
package scxo_pkg;
	localparam logic [7:0] CTRL_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] MASK_OFFSET = 8'h1c;
	localparam logic [7:0] CONTROL_OFFSET = 8'h20;
	localparam logic [15:0] CTRL_RESET = 16'h0080;
	localparam logic [15:0] CTRL_WMASK = 16'h17ee;
	localparam int LOCK_BIT = 12;
	localparam int WARM_HI = 10;
	localparam int WARM_LO = 8;
	localparam int REQUEST_DRIVEN_RUN_BIT = 7;
	localparam int STDBY_BIT = 6;
	localparam int AAMP_BIT = 5;
	localparam int OUT32_BIT = 3;
	localparam int XTAL_BIT = 2;
	localparam int ENABLE_BIT = 1;
	localparam int STANDBY_CTL_BIT = 0;
	localparam int IRQ_READY_BIT = 0;
	localparam int IRQ_LOST_BIT = 1;
	localparam int IRQ_W = 2;
	localparam int SYNC_CYCLES = 3;
	localparam int ULP_CNT_W = 18;
	localparam int ULP_HZ = 32768;
	localparam int CLK_HZ = 100000000;
	localparam int ULP_DIV = CLK_HZ / ULP_HZ;
	typedef enum logic [3:0] {
		SCXO_OFF = 4'h1,
		SCXO_WARM = 4'h2,
		SCXO_SYNC = 4'h4,
		SCXO_READY = 4'h8
	} scxo_state_e;
	function automatic logic [ULP_CNT_W-1:0] warm_count(input logic [2:0] sel);
		case (sel)
			3'h0: warm_count = 18'h00001;
			3'h1: warm_count = 18'h00020;
			3'h2: warm_count = 18'h00800;
			3'h3: warm_count = 18'h01000;
			3'h4: warm_count = 18'h04000;
			3'h5: warm_count = 18'h08000;
			3'h6: warm_count = 18'h10000;
			default: warm_count = 18'h20000;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> scxo_tick.sv
// Divider making the ultra-low-power 32 kHz tick as a one-cycle enable
`timescale 1ns/100ps
`default_nettype none
module scxo_tick #(
	parameter int DIV = 3051
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	logic [15:0] cnt_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_ff == 16'(DIV - 1)) begin
			cnt_ff <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> scxo_xtal_model.sv
// Behavioural model of the external 32 kHz crystal or clock source
`timescale 1ns/100ps
`default_nettype none
module scxo_xtal_model #(
	parameter int DIV = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	// ****************
	// Oscillation
	// ****************
	int cnt_ff;
	// A stopped crystal gives no edges, so no stale tick survives a stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_ff <= 0;
			tick <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == DIV - 1) ? 0 : cnt_ff + 1;
			tick <= (cnt_ff == DIV - 1);
		end
	end
endmodule
`default_nettype wire

// >>> tb.sv
// Testbench of the slow crystal oscillator control
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic req = 1'b0;
	logic [31:0] rdat, q;
	logic ack, xtick, run, rdy, amp, o32, opad, ipad, irq;
	int error_cnt = 0;
	int cmp_count = 0;
	scxo_ctrl #(.ULP_DIV(4)) i_scxo_ctrl (.REF_CLK(clk), .RST(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CLK_REQUEST(req), .XOSC_CLK_TICK(xtick), .OSC_RUN(run),
		.OSC_READY(rdy), .AUTO_AMP_EN(amp), .CLK32_OUT_EN(o32),
		.XTAL_OUT_PAD_EN(opad), .XTAL_IN_PAD_EN(ipad), .IRQ(irq));
	scxo_xtal_model #(.DIV(3)) i_scxo_xtal_model (.clk(clk), .rst(rst),
		.run(run), .tick(xtick));
	always #5 clk = ~clk;
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		chk("bus ack", 1, n < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Warm-up ticks may land anywhere in one divider period
	task automatic ready_in(input int w);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n <= w * 4 + 24) begin
			@(posedge clk);
			n++;
		end
		chk("ready time", 1, n >= (w - 1) * 4 + 6 && n <= w * 4 + 24);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		wb(1'b0, 8'h14, 0, q);
		chk("ctrl reset", 32'h80, q);
		wb(1'b0, 8'h40, 0, q);
		chk("unmapped read", 0, q);
		chk("run at reset", 0, run);
	endtask
	task automatic t_warm;
		int wc[3] = '{1, 32, 2048};
		for (int c = 0; c < 3; c++) begin
			wr(8'h14, 32'h2 | (c << 8));
			chk("run enabled", 1, run);
			ready_in(wc[c]);
			wr(8'h14, 0);
			chk("ready stopped", 0, rdy);
		end
	endtask
	task automatic t_pads;
		wr(8'h14, 32'h2e);
		ready_in(1);
		ticks(2);
		chk("amp on", 1, amp);
		chk("out32 on", 1, o32);
		chk("out pad crystal", 1, opad);
		chk("in pad", 1, ipad);
		wr(8'h14, 32'h2);
		ticks(1);
		chk("amp off", 0, amp);
		chk("out32 off", 0, o32);
		chk("out pad free", 0, opad);
		chk("in pad ext", 1, ipad);
	endtask
	task automatic t_demand;
		wr(8'h14, 32'h82);
		chk("no request", 0, run);
		req <= 1'b1;
		ticks(3);
		chk("requested", 1, run);
		ready_in(1);
		req <= 1'b0;
		ticks(3);
		chk("released", 0, run);
		chk("ready drop", 0, rdy);
	endtask
	task automatic t_standby;
		wr(8'h14, 32'h2);
		wr(8'h20, 1);
		ticks(2);
		chk("standby off", 0, run);
		wb(1'b0, 8'h20, 0, q);
		chk("standby reg", 32'h1, q);
		wr(8'h14, 32'h42);
		ticks(2);
		chk("standby kept", 1, run);
		wr(8'h14, 32'hc2);
		ticks(2);
		chk("standby demand", 0, run);
		wr(8'h20, 0);
		wr(8'h14, 0);
	endtask
	task automatic t_irq;
		wb(1'b0, 8'h18, 0, q);
		wr(8'h1c, 1);
		wr(8'h14, 32'h2);
		ready_in(1);
		ticks(3);
		chk("irq raised", 1, irq);
		wb(1'b0, 8'h18, 0, q);
		chk("status ready", 1, q[0]);
		ticks(3);
		chk("irq cleared", 0, irq);
		wr(8'h14, 0);
		ticks(3);
		chk("irq masked", 0, irq);
		wb(1'b0, 8'h18, 0, q);
		chk("status lost", 32'h2, q);
		wr(8'h1c, 0);
	endtask
	task automatic t_lock;
		wr(8'h14, 32'h1002);
		wr(8'h14, 0);
		wb(1'b0, 8'h14, 0, q);
		chk("locked ctrl", 32'h1002, q);
		chk("locked run", 1, run);
	endtask
	// ****************
	// Run control
	// ****************
	task automatic results;
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		ticks(4);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_warm();
		t_pads();
		t_demand();
		t_standby();
		t_irq();
		t_lock();
		results();
	end
	// Whole run needs about 10000 cycles
	initial begin
		#400000;
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
